/* File: design/sec_pkg.sv */
// constants for the code security settings block
// assumes a single clock domain and an apb register slave in front of it
package sec_pkg;

// ======================================
// register map (byte addresses)
localparam logic [11:0] OFS_SEC = 12'h000;
localparam logic [11:0] OFS_CMD = 12'h004;
localparam logic [11:0] OFS_STATUS = 12'h008;

// ======================================
// security byte layout and reset value
localparam logic [7:0] SEC_ERASED = 8'hff;
localparam logic [7:0] SEC_RSVD_MASK = 8'hcc;
localparam int LOCK_POS = 0;
localparam int INHIBIT_POS = 1;
localparam int DUAL_POS = 4;
localparam int SINGLE_POS = 5;

// ======================================
// command and status fields
localparam int CMD_ERASE_POS = 0;
localparam int ST_PROG_POS = 0;
localparam int ST_LOCKED_POS = 1;
localparam int ST_LOADER_POS = 2;
localparam int ST_DUAL_HIT_POS = 3;
localparam int ST_SINGLE_HIT_POS = 4;

// ======================================
// synchroniser depth and the idle pin levels its flops reset to
localparam int SYNC_DEPTH_DEF = 2;
// order {pin_c, pin_b, pin_a, reset_pin, prog_mode}: selects high, others low
localparam logic [4:0] PIN_IDLE = 5'h1c;

endpackage

/* File: design/sec_store_if.sv */
// carrier between the security control logic and the security byte store
// assumes both ends sit on the same clock
`timescale 1ns/1ns
interface sec_store_if;
	logic clear_en;
	logic [7:0] clear_data;
	logic erase_all;
	logic [7:0] bits;
	modport ctrl (output clear_en, output clear_data, output erase_all, input bits);
	modport store (input clear_en, input clear_data, input erase_all, output bits);
endinterface

/* File: design/sec_store.sv */
// nonvolatile-style security byte: bits only fall, erase-all restores them
// assumes requests arrive on clk_sys; reset models a freshly erased part
`timescale 1ns/1ns
module sec_store
	import sec_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	sec_store_if.store port
);

	logic [7:0] bits_ff;
	logic [7:0] nxt_bits;

	// ======================================
	// next value
	always_comb begin
		nxt_bits = bits_ff;
		if (port.erase_all) begin
			nxt_bits = SEC_ERASED;
		end else if (port.clear_en) begin
			// and-only update: a cleared bit never returns by programming
			nxt_bits = bits_ff & (port.clear_data | SEC_RSVD_MASK);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bits_ff <= SEC_ERASED;
		end else begin
			bits_ff <= nxt_bits;
		end
	end

	assign port.bits = bits_ff;

	// ======================================
	// checks
	a_no_rise_store: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(port.erase_all) |-> ((bits_ff & ~$past(bits_ff)) == 8'h00))
		else $error("security bit rose without erase-all");
	a_erase_restores: assert property (@(posedge clk_sys) disable iff (rst)
		port.erase_all |=> bits_ff == SEC_ERASED)
		else $error("erase-all did not restore security byte");
	a_rsvd_kept: assert property (@(posedge clk_sys) disable iff (rst)
		(bits_ff & SEC_RSVD_MASK) == SEC_RSVD_MASK)
		else $error("reserved security bit cleared");

endmodule

/* File: design/code_security.sv */
// code security settings: apb slave for the programmer, table read gating,
// hardware reboot into the loader flash bank
// assumes apb on clk_sys; pins and the reset pin level are asynchronous
`timescale 1ns/1ns
module code_security
	import sec_pkg::*;
#(
	parameter int SYNC_DEPTH = SYNC_DEPTH_DEF
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic prog_mode_pin,
	input wire logic reset_pin,
	input wire logic reboot_select_pin_a,
	input wire logic reboot_select_pin_b,
	input wire logic reboot_select_pin_c,
	input wire logic code_table_read,
	input wire logic exec_from_external,
	input wire logic target_internal,
	output logic table_read_internal,
	output logic table_read_external,
	output logic flash_access_allow,
	output logic fetch_from_loader_flash
);

	if (SYNC_DEPTH < 2) begin : g_bad_depth
		$error("SYNC_DEPTH must be at least 2");
	end

	// ======================================
	// pin synchronisers
	localparam int NPIN = 5;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync_ff [SYNC_DEPTH];
	logic [NPIN-1:0] pin_s;

	assign pin_raw = {reboot_select_pin_c, reboot_select_pin_b, reboot_select_pin_a, reset_pin, prog_mode_pin};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			// idle levels, not all ones: a mode pin seen high out of reset
			// would open flash access for two edges before the pins arrive
			for (int i = 0; i < SYNC_DEPTH; i++) begin
				sync_ff[i] <= PIN_IDLE;
			end
		end else begin
			sync_ff[0] <= pin_raw;
			for (int i = 1; i < SYNC_DEPTH; i++) begin
				sync_ff[i] <= sync_ff[i-1];
			end
		end
	end

	assign pin_s = sync_ff[SYNC_DEPTH-1];

	logic prog_mode_s;
	logic reset_pin_s;
	logic pin_a_s;
	logic pin_b_s;
	logic pin_c_s;
	assign prog_mode_s = pin_s[0];
	assign reset_pin_s = pin_s[1];
	assign pin_a_s = pin_s[2];
	assign pin_b_s = pin_s[3];
	assign pin_c_s = pin_s[4];

	// ======================================
	// security byte store
	sec_store_if st_if ();

	sec_store u_store (
		.clk_sys(clk_sys),
		.rst(rst),
		.port(st_if.store)
	);

	logic [7:0] sec_bits;
	logic lock_bit;
	logic table_read_inhibit_bit;
	logic dual_pin_reboot_enable;
	logic single_pin_reboot_enable;
	assign sec_bits = st_if.bits;
	assign lock_bit = sec_bits[LOCK_POS];
	assign table_read_inhibit_bit = sec_bits[INHIBIT_POS];
	assign dual_pin_reboot_enable = sec_bits[DUAL_POS];
	assign single_pin_reboot_enable = sec_bits[SINGLE_POS];

	// ======================================
	// apb slave: one wait state so read data come from a flop
	logic ack_ff;
	logic nxt_ack;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic err_ff;
	logic nxt_err;
	logic access;
	logic done;
	logic hit_sec;
	logic hit_cmd;
	logic hit_status;
	logic sec_ok;
	logic [7:0] status_byte;

	assign access = psel & penable;
	assign done = access & ack_ff;
	assign hit_sec = paddr == OFS_SEC;
	assign hit_cmd = paddr == OFS_CMD;
	assign hit_status = paddr == OFS_STATUS;
	// security byte only in programming mode and while unlocked
	assign sec_ok = prog_mode_s & lock_bit;

	always_comb begin
		nxt_ack = access & ~ack_ff;
		nxt_rdata = rdata_ff;
		nxt_err = err_ff;
		if (access & ~ack_ff) begin
			nxt_rdata = 32'h0000_0000;
			nxt_err = 1'b0;
			if (hit_sec) begin
				nxt_err = ~sec_ok;
				if (sec_ok & ~pwrite) begin
					nxt_rdata = {24'h00_0000, sec_bits};
				end
			end else if (hit_cmd) begin
				// erase-all is the only way out of the lock, so the lock bit never refuses it; only programming mode does
				nxt_err = ~prog_mode_s;
			end else if (hit_status) begin
				nxt_err = pwrite;
				if (~pwrite) begin
					nxt_rdata = {24'h00_0000, status_byte};
				end
			end else begin
				nxt_err = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			err_ff <= 1'b0;
		end else begin
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
			err_ff <= nxt_err;
		end
	end

	assign pready = ack_ff;
	assign prdata = rdata_ff;
	assign pslverr = ack_ff & err_ff;

	// writes land only at the completing edge and only when not refused
	// the gate is checked again at the commit edge: the mode pin may fall
	// inside the access phase, and then the write is dropped
	assign st_if.clear_en = done & pwrite & hit_sec & ~err_ff & sec_ok & pstrb[0];
	assign st_if.clear_data = pwdata[7:0];
	assign st_if.erase_all = done & pwrite & hit_cmd & ~err_ff & prog_mode_s & pstrb[0]
		& pwdata[CMD_ERASE_POS];

	// flash array access for the programmer follows the same gate
	assign flash_access_allow = prog_mode_s & lock_bit;

	// ======================================
	// code table read routing
	always_comb begin
		table_read_internal = 1'b0;
		table_read_external = 1'b0;
		if (code_table_read) begin
			if (exec_from_external & ~table_read_inhibit_bit) begin
				table_read_external = 1'b1;
			end else begin
				// internal code, or inhibit off: the request goes where it points
				table_read_internal = target_internal;
				table_read_external = ~target_internal;
			end
		end
	end

	// ======================================
	// hardware reboot into the loader flash bank
	logic dual_hit;
	logic single_hit;
	logic loader_ff;
	logic nxt_loader;
	logic dual_hit_ff;
	logic nxt_dual_hit;
	logic single_hit_ff;
	logic nxt_single_hit;

	assign dual_hit = ~dual_pin_reboot_enable & ~pin_a_s & ~pin_b_s;
	assign single_hit = ~single_pin_reboot_enable & ~pin_c_s;

	// pins are sampled continuously while the reset pin is high;
	// the last sample before release decides the boot bank
	always_comb begin
		nxt_loader = loader_ff;
		nxt_dual_hit = dual_hit_ff;
		nxt_single_hit = single_hit_ff;
		if (reset_pin_s) begin
			nxt_loader = dual_hit | single_hit;
			nxt_dual_hit = dual_hit;
			nxt_single_hit = single_hit;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			loader_ff <= 1'b0;
			dual_hit_ff <= 1'b0;
			single_hit_ff <= 1'b0;
		end else begin
			loader_ff <= nxt_loader;
			dual_hit_ff <= nxt_dual_hit;
			single_hit_ff <= nxt_single_hit;
		end
	end

	assign fetch_from_loader_flash = loader_ff;

	assign status_byte = {3'h0, single_hit_ff, dual_hit_ff, loader_ff, ~lock_bit, prog_mode_s};

	// ======================================
	// checks
	a_sec_needs_mode: assert property (@(posedge clk_sys) disable iff (rst)
		st_if.clear_en |-> prog_mode_s && lock_bit)
		else $error("security byte written outside programming mode");
	a_sec_refused: assert property (@(posedge clk_sys) disable iff (rst)
		(access && !ack_ff && hit_sec && !prog_mode_s) |=> pready && pslverr)
		else $error("security access outside programming mode not refused");
	a_lock_refuses: assert property (@(posedge clk_sys) disable iff (rst)
		(access && !ack_ff && hit_sec && !lock_bit) |=> pslverr && prdata == 32'h0000_0000)
		else $error("locked security byte still reachable");
	a_lock_flash: assert property (@(posedge clk_sys) disable iff (rst)
		!lock_bit |-> !flash_access_allow)
		else $error("flash access allowed while locked");
	a_inhibit_ext: assert property (@(posedge clk_sys) disable iff (rst)
		(code_table_read && exec_from_external && !table_read_inhibit_bit) |->
			(table_read_external && !table_read_internal))
		else $error("inhibited table read reached internal code");
	a_internal_free: assert property (@(posedge clk_sys) disable iff (rst)
		(code_table_read && !exec_from_external) |-> table_read_internal == target_internal)
		else $error("internal table read misrouted");
	a_no_inhibit: assert property (@(posedge clk_sys) disable iff (rst)
		(code_table_read && table_read_inhibit_bit) |->
			(table_read_internal ^ table_read_external) && table_read_internal == target_internal)
		else $error("table read restricted with inhibit off");
	a_dual_boot: assert property (@(posedge clk_sys) disable iff (rst)
		(reset_pin_s && !dual_pin_reboot_enable && !pin_a_s && !pin_b_s) ##1 !reset_pin_s[*2]
			|-> fetch_from_loader_flash)
		else $error("dual pin reboot not taken");
	a_single_boot: assert property (@(posedge clk_sys) disable iff (rst)
		(reset_pin_s && !single_pin_reboot_enable && !pin_c_s) |=> fetch_from_loader_flash)
		else $error("single pin reboot not taken");
	a_no_boot_default: assert property (@(posedge clk_sys) disable iff (rst)
		(reset_pin_s && dual_pin_reboot_enable && single_pin_reboot_enable) |=> !fetch_from_loader_flash)
		else $error("loader boot without enabled condition");
	a_boot_held: assert property (@(posedge clk_sys) disable iff (rst)
		(!reset_pin_s && !$past(reset_pin_s)) |-> $stable(fetch_from_loader_flash))
		else $error("boot bank changed outside reset");

endmodule

/* File: tb/sec_programmer.sv */
// device programmer model: apb master that reaches the security byte
// assumes the slave answers with a one-cycle pready on clk_sys
`timescale 1ns/1ns
module sec_programmer (
	input wire logic clk_sys,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic [11:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb
);
	// ======================================
	// idle bus
	initial begin
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h00000000;
		pstrb = 4'hf;
	end
	// ======================================
	// one transfer, held until pready is sampled high or 16 edges pass
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output logic to);
		to = 1'b1;
		rd = 32'h00000000;
		err = 1'b0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (int n = 0; n < 16; n++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) begin
				rd = prdata;
				err = pslverr;
				to = 1'b0;
				break;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// released address and data lines show the inverse so stale values cannot pass
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

/* File: tb/tb_code_security.sv */
// self-checking bench for the code security block
// assumes sec_programmer drives the apb side; pins come from here
`timescale 1ns/1ns
module tb_code_security
	import sec_pkg::*;
;
	logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, prog_mode_pin, reset_pin;
	logic pin_a, pin_b, pin_c, code_table_read, exec_from_external, target_internal;
	logic table_read_internal, table_read_external, flash_access_allow, fetch_from_loader_flash;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic err;
	int err_total = 0;
	int comparisons = 0;

	// ======================================
	// clock and instances
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	code_security #(.SYNC_DEPTH(2)) i_dut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .prog_mode_pin(prog_mode_pin), .reset_pin(reset_pin),
		.reboot_select_pin_a(pin_a), .reboot_select_pin_b(pin_b), .reboot_select_pin_c(pin_c),
		.code_table_read(code_table_read), .exec_from_external(exec_from_external),
		.target_internal(target_internal), .table_read_internal(table_read_internal),
		.table_read_external(table_read_external), .flash_access_allow(flash_access_allow),
		.fetch_from_loader_flash(fetch_from_loader_flash));
	sec_programmer i_prog (.clk_sys(clk_sys), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb));

	// ======================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		logic to;
		i_prog.xfer(w, a, d, rd, err, to);
		if (to) begin
			err_total++;
			close_out();
		end
	endtask
	// synchronisers need 2 edges, the reboot flop one more
	task automatic pins(input logic rp, input logic [2:0] abc, input logic exp);
		@(posedge clk_sys);
		reset_pin <= rp;
		{pin_a, pin_b, pin_c} <= abc;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		check({31'h0, fetch_from_loader_flash}, {31'h0, exp});
	endtask
	task automatic table_rd(input logic ext, input logic tint, input logic [1:0] exp);
		@(posedge clk_sys);
		code_table_read <= 1'b1;
		exec_from_external <= ext;
		target_internal <= tint;
		@(negedge clk_sys);
		check({30'h0, table_read_internal, table_read_external}, {30'h0, exp});
	endtask

	// ======================================
	// scenarios
	task automatic t_mode();
		bus(1'b0, OFS_SEC, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		bus(1'b1, OFS_CMD, 32'h00000001);
		check({31'h0, err}, 32'h1);
		prog_mode_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		bus(1'b0, OFS_SEC, 32'h0);
		check(rd, 32'h000000ff);
		bus(1'b0, 12'h0fc, 32'h0);
		check({31'h0, err}, 32'h1);
		bus(1'b1, OFS_STATUS, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("test mode done");
	endtask
	task automatic t_clear();
		bus(1'b1, OFS_SEC, 32'h000000cd);
		bus(1'b1, OFS_SEC, 32'h000000ff);
		bus(1'b0, OFS_SEC, 32'h0);
		check(rd, 32'h000000cd);
		bus(1'b1, OFS_SEC, 32'h00000031);
		bus(1'b0, OFS_SEC, 32'h0);
		check(rd, 32'h000000cd);
		table_rd(1'b1, 1'b1, 2'b01);
		table_rd(1'b0, 1'b1, 2'b10);
		table_rd(1'b0, 1'b0, 2'b01);
		$display("test clear done");
	endtask
	task automatic t_reboot();
		pins(1'b1, 3'b111, 1'b0);
		pins(1'b1, 3'b001, 1'b1);
		pins(1'b0, 3'b001, 1'b1);
		pins(1'b1, 3'b101, 1'b0);
		pins(1'b1, 3'b110, 1'b1);
		// status: mode on, unlocked, loader boot, single-pin hit only
		bus(1'b0, OFS_STATUS, 32'h0);
		check(rd, 32'h00000015);
		pins(1'b0, 3'b111, 1'b1);
		$display("test reboot done");
	endtask
	task automatic t_erase();
		bus(1'b1, OFS_CMD, 32'h00000001);
		bus(1'b0, OFS_SEC, 32'h0);
		check(rd, 32'h000000ff);
		table_rd(1'b1, 1'b1, 2'b10);
		pins(1'b1, 3'b000, 1'b0);
		$display("test erase done");
	endtask
	task automatic t_lock();
		// lock goes last, once the byte has been verified
		bus(1'b1, OFS_SEC, 32'h000000fe);
		bus(1'b0, OFS_SEC, 32'h0);
		check({31'h0, err}, 32'h1);
		check({31'h0, flash_access_allow}, 32'h0);
		bus(1'b1, OFS_CMD, 32'h00000001);
		bus(1'b0, OFS_SEC, 32'h0);
		check(rd, 32'h000000ff);
		check({31'h0, flash_access_allow}, 32'h1);
		$display("test lock done");
	endtask

	// ======================================
	// main sequence
	initial begin
		rst = 1'b1;
		prog_mode_pin = 1'b0;
		reset_pin = 1'b0;
		{pin_a, pin_b, pin_c} = 3'b111;
		code_table_read = 1'b0;
		exec_from_external = 1'b0;
		target_internal = 1'b0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		t_mode();
		t_clear();
		t_reboot();
		t_erase();
		t_lock();
		close_out();
	end
endmodule
